// >>> rtl/rse_execute.sv
`include "rse_params.svh"

// Notes on behaviour
// RL1: rotate_left_via_carry: shift left, old carry into bit 0, bit 7 to carry.
// RL2: rotate_right_via_carry: shift right, old carry into bit 7, bit 0 to carry.
// RL3: destination bit 0 writes accumulator, 1 writes addressed file register.
// RL4: rotates change only status bit 0, the carry.
// RL5: sleep sets timeout_flag to 1 and clears powerdown_flag to 0.
// RL6: sleep clears watchdog_counter, and its prescaler when assigned to it.
// RL7: after sleep, core halts and oscillator stops until wake-up.
// RL8: each operation is one word, completes in one instruction cycle.
module rse_execute
  import rse_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire logic [11:0] instr_i,
  input wire logic [7:0] file_data_i,
  input wire logic prescaler_to_wdt_i,
  input wire logic wake_i,
  output logic [4:0] file_idx_o,
  output rse_fwr_t file_wr_o,
  output logic [7:0] wreg_o,
  output logic [7:0] status_o,
  output logic wdt_clear_o,
  output logic prescaler_clear_o,
  output logic sleeping_o,
  output logic osc_enable_o
);
  // ==========================================
  // decode
  rse_op_t op;
  logic exec;

  // classifier kept apart so further opcodes can join it later
  rse_decode rse_decode_i (
    .instr_i(instr_i),
    .op_o(op)
  );

  // a halted core accepts nothing; no sign is given on the port
  assign exec = instr_valid_i && !sleeping_o;
  // read address goes straight from the operand field
  assign file_idx_o = instr_i[`RSE_IDX_MSB:`RSE_IDX_LSB];

  // ==========================================
  // datapath state
  logic [7:0] wreg, next_wreg;
  logic [7:0] status, next_status;
  rse_fwr_t file_wr, next_file_wr;
  logic wdt_clr, next_wdt_clr;
  logic ps_clr, next_ps_clr;
  logic sleeping, next_sleeping;
  logic [7:0] rot_res;
  logic rot_carry;

  // rotate result; carry taken from current status so chains work
  always_comb begin
    rot_res = 8'h00;
    rot_carry = status[`RSE_CARRY_BIT];
    if (op == RSE_OP_ROTL) begin
      rot_res = {file_data_i[6:0], status[`RSE_CARRY_BIT]}; // see RL1
      rot_carry = file_data_i[7]; // see RL1
    end else if (op == RSE_OP_ROTR) begin
      rot_res = {status[`RSE_CARRY_BIT], file_data_i[7:1]}; // see RL2
      rot_carry = file_data_i[0]; // see RL2
    end
  end

  // next values: one instruction resolves fully in one cycle
  always_comb begin
    next_wreg = wreg;
    next_status = status;
    next_file_wr = '0;
    next_wdt_clr = 1'b0;
    next_ps_clr = 1'b0;
    next_sleeping = sleeping;
    if (sleeping) begin
      // halted; only a wake-up source releases the core
      if (wake_i) begin
        next_sleeping = 1'b0;
      end
    end else if (instr_valid_i) begin
      case (op)
        RSE_OP_ROTL, RSE_OP_ROTR: begin
          next_status[`RSE_CARRY_BIT] = rot_carry; // see RL4
          if (instr_i[`RSE_DEST_BIT]) begin
            next_file_wr.we = 1'b1; // see RL3
            next_file_wr.idx = instr_i[`RSE_IDX_MSB:`RSE_IDX_LSB];
            next_file_wr.data = rot_res;
          end else begin
            next_wreg = rot_res; // see RL3
          end
        end
        RSE_OP_SLEEP: begin
          next_status[`RSE_TIMEOUT_BIT] = 1'b1; // timeout_flag, see RL5
          next_status[`RSE_POWERDOWN_BIT] = 1'b0; // powerdown_flag, see RL5
          next_wdt_clr = 1'b1; // see RL6
          // prescaler cleared only while the timer owns it
          next_ps_clr = prescaler_to_wdt_i; // see RL6
          next_sleeping = 1'b1; // see RL7
        end
        default: begin
        end
      endcase
    end
  end

  // register stage; results visible to the next instruction
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wreg <= `RSE_RST_WREG;
      status <= `RSE_RST_STATUS;
      file_wr <= '0;
      wdt_clr <= 1'b0;
      ps_clr <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      wreg <= next_wreg; // see RL8
      status <= next_status;
      file_wr <= next_file_wr;
      wdt_clr <= next_wdt_clr;
      ps_clr <= next_ps_clr;
      sleeping <= next_sleeping;
    end
  end

  // outputs straight from the flip-flops, except osc_enable_o, which is the inverted sleeping flag
  assign wreg_o = wreg;
  assign status_o = status;
  assign file_wr_o = file_wr;
  assign wdt_clear_o = wdt_clr;
  assign prescaler_clear_o = ps_clr;
  assign sleeping_o = sleeping;
  assign osc_enable_o = !sleeping; // see RL7

  // ==========================================
  // assertions
  // named steps; antecedents only see words that the core accepts
  sequence s_rotl_issue;
    exec && op == RSE_OP_ROTL;
  endsequence

  sequence s_rotr_issue;
    exec && op == RSE_OP_ROTR;
  endsequence

  sequence s_rot_issue;
    exec && (op == RSE_OP_ROTL || op == RSE_OP_ROTR);
  endsequence

  sequence s_sleep_issue;
    exec && op == RSE_OP_SLEEP;
  endsequence

  // halted, no wake-up source present
  sequence s_dozing;
    sleeping_o && !wake_i;
  endsequence

  // halted, a wake-up source present
  sequence s_waking;
    sleeping_o && wake_i;
  endsequence

  // rotate checks: result, carry and destination
  AST_ROTL_RESULT: assert property (@(posedge clock_i) disable iff (reset_i) // see RL1
    s_rotl_issue |=> (status[0] == $past(file_data_i[7])) &&
      ($past(instr_i[5]) ? file_wr.data == {$past(file_data_i[6:0]), $past(status[0])}
                         : wreg == {$past(file_data_i[6:0]), $past(status[0])}))
    else $error("left rotate result wrong");

  AST_ROTR_RESULT: assert property (@(posedge clock_i) disable iff (reset_i) // see RL2
    s_rotr_issue |=> (status[0] == $past(file_data_i[0])) &&
      ($past(instr_i[5]) ? file_wr.data == {$past(status[0]), $past(file_data_i[7:1])}
                         : wreg == {$past(status[0]), $past(file_data_i[7:1])}))
    else $error("right rotate result wrong");

  AST_ROT_DEST: assert property (@(posedge clock_i) disable iff (reset_i) // see RL3
    s_rot_issue |=> file_wr.we == $past(instr_i[`RSE_DEST_BIT]) &&
      (!file_wr.we || (wreg == $past(wreg) &&
      file_wr.idx == $past(instr_i[`RSE_IDX_MSB:`RSE_IDX_LSB]))))
    else $error("rotate destination wrong");

  AST_ROT_FLAGS: assert property (@(posedge clock_i) disable iff (reset_i) // see RL4
    s_rot_issue |=> status[7:1] == $past(status[7:1]))
    else $error("rotate touched other flags");

  AST_ROT_RUNS_ON: assert property (@(posedge clock_i) disable iff (reset_i) // see RL8
    s_rot_issue |=> !wdt_clear_o && !prescaler_clear_o && !sleeping_o)
    else $error("rotate disturbed watchdog or halted core");

  // sleep checks: flags and watchdog clear pulses
  AST_SLEEP_FLAGS: assert property (@(posedge clock_i) disable iff (reset_i) // see RL5
    s_sleep_issue |=> status[`RSE_TIMEOUT_BIT] && !status[`RSE_POWERDOWN_BIT])
    else $error("sleep flags wrong");

  AST_SLEEP_WDT: assert property (@(posedge clock_i) disable iff (reset_i) // see RL6
    s_sleep_issue |=> wdt_clear_o && prescaler_clear_o == $past(prescaler_to_wdt_i)
      ##1 !wdt_clear_o && !prescaler_clear_o)
    else $error("watchdog clear wrong");

  // halt and wake checks
  AST_SLEEP_HALT: assert property (@(posedge clock_i) disable iff (reset_i) // see RL7
    s_sleep_issue |=> sleeping_o && !osc_enable_o)
    else $error("core not halted after sleep");

  AST_HALT_HOLDS: assert property (@(posedge clock_i) disable iff (reset_i) // see RL7
    s_dozing |=> sleeping_o && !osc_enable_o)
    else $error("core left sleep without a wake-up source");

  AST_HALT_IGNORES: assert property (@(posedge clock_i) disable iff (reset_i) // see RL7
    sleeping_o |=> !file_wr.we && wreg == $past(wreg) && status == $past(status))
    else $error("halted core executed an instruction");

  AST_WAKE_RELEASE: assert property (@(posedge clock_i) disable iff (reset_i) // see RL7
    s_waking |=> !sleeping_o && osc_enable_o)
    else $error("wake-up source did not release the core");

  // timing checks: strobes last one cycle and need an accepted word
  AST_ONE_CYCLE: assert property (@(posedge clock_i) disable iff (reset_i) // see RL8
    file_wr.we |=> !file_wr.we || $past(exec))
    else $error("write strobe held longer than one cycle");

  AST_IDLE_QUIET: assert property (@(posedge clock_i) disable iff (reset_i) // see RL8
    !exec |=> !file_wr.we && !wdt_clear_o && !prescaler_clear_o)
    else $error("strobe without an accepted instruction");
endmodule

// >>> pkg/rse_params.svh
`ifndef RSE_PARAMS_SVH
`define RSE_PARAMS_SVH

// ==========================================
// opcode patterns (12-bit instruction word)
`define RSE_OP_ROT_MASK 12'hfc0
`define RSE_OP_ROTL_VAL 12'h340
`define RSE_OP_ROTR_VAL 12'h300
`define RSE_OP_SLEEP 12'h003
// ==========================================
// field positions
`define RSE_DEST_BIT 5
`define RSE_IDX_LSB 0
`define RSE_IDX_MSB 4
`define RSE_CARRY_BIT 0
`define RSE_POWERDOWN_BIT 3
`define RSE_TIMEOUT_BIT 4
// ==========================================
// reset values
`define RSE_RST_STATUS 8'h18
`define RSE_RST_WREG 8'h00
`define RSE_WDT_CLEAR 8'h00

`endif

// >>> pkg/rse_pkg.sv
package rse_pkg;
  // ==========================================
  // decoded operation
  typedef enum {
    RSE_OP_NONE,
    RSE_OP_ROTL,
    RSE_OP_ROTR,
    RSE_OP_SLEEP
  } rse_op_t;

  // file-register write-back request
  typedef struct packed {
    logic       we;
    logic [4:0] idx;
    logic [7:0] data;
  } rse_fwr_t;
endpackage

// >>> rtl/rse_decode.sv
`include "rse_params.svh"

// ==========================================
// opcode classifier
module rse_decode
  import rse_pkg::*;
(
  input wire logic [11:0] instr_i,
  output rse_op_t op_o
);
  // pattern match on the fixed opcode bits
  always_comb begin
    if ((instr_i & `RSE_OP_ROT_MASK) == `RSE_OP_ROTL_VAL) begin
      op_o = RSE_OP_ROTL;
    end else if ((instr_i & `RSE_OP_ROT_MASK) == `RSE_OP_ROTR_VAL) begin
      op_o = RSE_OP_ROTR;
    end else if (instr_i == `RSE_OP_SLEEP) begin
      op_o = RSE_OP_SLEEP;
    end else begin
      op_o = RSE_OP_NONE;
    end
  end
endmodule

// >>> verification/rse_file_model.sv
// ====
// file register array on the far side
module rse_file_model
  import rse_pkg::*;
(
  input wire logic clock_i,
  input wire logic [4:0] file_idx_i,
  input wire rse_fwr_t file_wr_i,
  output logic [7:0] file_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [32];
  // scrambled start so both end bits get exercised
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'(i * 37 + 6);
    end
  end
  // combinational read, same cycle as the index
  assign file_data_o = mem[file_idx_i];
  // write-back lands one edge after the pulse
  always @(posedge clock_i) begin
    if (file_wr_i.we) begin
      mem[file_wr_i.idx] <= file_wr_i.data;
    end
  end
endmodule

// >>> verification/rotate_and_sleep_execute_tb_top.sv
// ====
// bench for the rotate and sleep datapath
module rotate_and_sleep_execute_tb_top
  import rse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'h0;
  logic reset_i = 1'h1;
  logic instr_valid_i = 1'h0;
  logic [11:0] instr_i = 12'h000;
  logic prescaler_to_wdt_i = 1'h0;
  logic wake_i = 1'h0;
  logic [7:0] file_data_i, wreg_o, status_o;
  logic [4:0] file_idx_o;
  rse_fwr_t file_wr_o;
  logic wdt_clear_o, prescaler_clear_o, sleeping_o, osc_enable_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 60528;
  rse_execute rse_execute_i (.clock_i(clock_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .file_data_i(file_data_i),
    .prescaler_to_wdt_i(prescaler_to_wdt_i), .wake_i(wake_i), .file_idx_o(file_idx_o),
    .file_wr_o(file_wr_o), .wreg_o(wreg_o), .status_o(status_o),
    .wdt_clear_o(wdt_clear_o), .prescaler_clear_o(prescaler_clear_o),
    .sleeping_o(sleeping_o), .osc_enable_o(osc_enable_o));
  rse_file_model rse_file_model_i (.clock_i(clock_i), .file_idx_i(file_idx_o),
    .file_wr_i(file_wr_o), .file_data_o(file_data_i));
  // ====
  // 50 ns clock
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // expected {carry, result} of a rotate through carry
  function automatic logic [8:0] rot_expect(input logic left, input logic [7:0] fd,
                                            input logic c);
    rot_expect = left ? {fd, c} : {fd[0], c, fd[7:1]};
  endfunction
  // one idle cycle after each op so the write-back lands before the next read
  task automatic rot(input logic [11:0] ins, input logic asleep);
    logic [7:0] fd, st, w, r;
    logic nc;
    @(negedge clock_i);
    instr_i = ins;
    instr_valid_i = 1'h1;
    #1;
    chk({3'h0, file_idx_o}, {3'h0, ins[4:0]});
    fd = file_data_i;
    st = status_o;
    w = wreg_o;
    {nc, r} = rot_expect(ins[6], fd, st[0]);
    @(negedge clock_i);
    instr_valid_i = 1'h0;
    chk(status_o, asleep ? st : {st[7:1], nc});
    chk(wreg_o, (asleep || ins[5]) ? w : r);
    chk({7'h0, file_wr_o.we}, {7'h0, !asleep && ins[5]});
    if (!asleep && ins[5]) begin
      chk(file_wr_o.data, r);
      chk({3'h0, file_wr_o.idx}, {3'h0, ins[4:0]});
    end
  endtask
  task automatic slp(input logic pa);
    logic [7:0] st;
    @(negedge clock_i);
    instr_i = 12'h003;
    instr_valid_i = 1'h1;
    prescaler_to_wdt_i = pa;
    st = status_o;
    @(negedge clock_i);
    instr_valid_i = 1'h0;
    chk(status_o, {st[7:5], 2'h2, st[2:0]});
    chk({6'h0, wdt_clear_o, prescaler_clear_o}, {6'h0, 1'h1, pa});
    chk({6'h0, sleeping_o, osc_enable_o}, 8'h02);
    @(negedge clock_i);
    chk({6'h0, wdt_clear_o, prescaler_clear_o}, 8'h00);
  endtask
  // ====
  // main sequence: random rotates, then sleep with and without prescaler
  initial begin
    logic [31:0] r;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    reset_i = 1'h0;
    chk(status_o, 8'h18);
    for (int k = 0; k < 2; k++) begin
      repeat (100) begin
        r = $random(seed);
        rot({5'h06, r[6:0]}, 1'h0);
      end
      slp(k[0]);
      rot(12'h361, 1'h1);
      @(negedge clock_i);
      wake_i = 1'h1;
      @(negedge clock_i);
      wake_i = 1'h0;
      chk({6'h0, sleeping_o, osc_enable_o}, 8'h01);
    end
    give_verdict();
  end
  // hang guard, well past the expected run
  initial begin
    #(2000 * 50);
    error_cnt++;
    give_verdict();
  end
endmodule
